//--- rtl/gpio_pad_defines.vh
// Constants for the per-pin pad logic: register offsets, field positions,
// reset values and mode codes.
// Assumes inclusion by bare name from the design file only.
`ifndef GPIO_PAD_DEFINES_VH
`define GPIO_PAD_DEFINES_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define GP_OFS_CTRL 4'h0
`define GP_OFS_STATUS 4'h4

// ****************************************************************
// Control field positions
// ****************************************************************
`define GP_MODE_LSB 0
`define GP_MODE_MSB 2
`define GP_IN_REG 3
`define GP_IN_NEG 4
`define GP_OUT_REG 5
`define GP_OUT_NEG 6
`define GP_OUT_INV 7
`define GP_DUAL_IN 8
`define GP_DUAL_OUT 9
`define GP_RESYNC 10
`define GP_BYPASS 11
`define GP_PULL_DOWN 12
`define GP_DIFF_PIN 13
`define GP_CTRL_BITS 14
`define GP_CTRL_RESET 14'h0000

// ****************************************************************
// Mode codes
// ****************************************************************
`define GP_MODE_UNUSED 3'h0
`define GP_MODE_INPUT 3'h1
`define GP_MODE_OUTPUT 3'h2
`define GP_MODE_BIDIR 3'h3
`define GP_MODE_CLKOUT 3'h4

// ****************************************************************
// Status field positions
// ****************************************************************
`define GP_ST_PAD 0
`define GP_ST_RISE 1
`define GP_ST_FALL 2
`define GP_ST_DRIVE 3
`define GP_ST_CONFIG 4

`endif

//--- rtl/gpio_pad_io_logic.v
// Per-pin general-purpose I/O logic between core fabric and one pad.
// Assumes a classic Wishbone master on clk_i, core-side data on clk_i,
// and pad, capture/launch clocks and clock-tree inputs arriving
// asynchronously; all of those are synchronised before use.
//
// Contract
// - Input mode enables receive only; pad reaches core direct or via capture register.
// - Registered receive path is clocked by capture clock, selectable edge.
// - Bypass input forwards the pad unregistered to the alternate function.
// - Bypass input drives another interface block without passing to the core.
// - Dual-edge input samples pad on both capture clock edges into two bits, except on differential pins.
// - Output mode enables transmit only; core data drives pad direct or registered.
// - Registered transmit path is clocked by launch clock, selectable edge.
// - Option inverts output register value, in output and bidirectional modes.
// - Dual-edge output captures on both launch edges and, except on differential pins, muxes onto the pad.
// - Bidirectional mode enables receive, transmit and drive-enable paths.
// - Bidirectional registers: capture clock for input, launch clock for output and enable.
// - Bidirectional receive and transmit registering chosen independently.
// - Clock output mode drives the core clock tree straight onto the pad.
// - During configuration ordinary pins hold a weak pull-up.
// - Differential pins used single-ended float during configuration, no pulls.
// - Unused pins float with weak pull-up by default, pull-down selectable except on differential pins.
// - Dual-edge input: first bit rising sample, second bit falling sample.
// - Resync mode delays falling sample half a cycle; both bits change on rise.
`include "gpio_pad_defines.vh"

module gpio_pad_io_logic (
  input wire clk_i,
  input wire rst_i,
  // Wishbone classic slave
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [3:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  // Device configuration in progress
  input wire config_active_i,
  // Core-side clocks, asynchronous to clk_i
  input wire capture_clock_i,
  input wire launch_clock_i,
  input wire clock_tree_i,
  // Core fabric data, on clk_i
  input wire rise_drive_bit_i,
  input wire fall_drive_bit_i,
  input wire drive_enable_i,
  output reg rise_sample_bit_o,
  output reg fall_sample_bit_o,
  // Alternate function of the pad, bypassing the core
  output reg bypass_input_o,
  // Pad buffer
  input wire pad_i,
  output reg pad_o,
  output reg pad_oe_o,
  output reg pull_up_o,
  output reg pull_down_o
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function edge_hit;
    input neg;
    input rise;
    input fall;
    begin
      edge_hit = neg ? fall : rise;
    end
  endfunction

  function mode_is;
    input [2:0] m;
    input [2:0] code;
    begin
      mode_is = (m == code);
    end
  endfunction

  function apply_inv;
    input d;
    input inv;
    begin
      apply_inv = d ^ inv;
    end
  endfunction

  // ****************************************************************
  // Control register and bus slave
  // ****************************************************************
  reg [`GP_CTRL_BITS-1:0] ctrl;
  // Pad level after the two-flop synchroniser; also read back through status
  reg pad_s1, pad_s2;
  wire bus_req = cyc_i & stb_i & ~ack_o;
  // Writes land on the edge at which the master sees ack, never one edge early
  wire bus_done = cyc_i & stb_i & ack_o;
  wire hit_ctrl = (adr_i == `GP_OFS_CTRL);
  wire hit_status = (adr_i == `GP_OFS_STATUS);

  wire [2:0] mode = ctrl[`GP_MODE_MSB:`GP_MODE_LSB];
  wire in_reg = ctrl[`GP_IN_REG];
  wire in_neg = ctrl[`GP_IN_NEG];
  wire out_reg = ctrl[`GP_OUT_REG];
  wire out_neg = ctrl[`GP_OUT_NEG];
  wire out_inv = ctrl[`GP_OUT_INV];
  wire diff_pin = ctrl[`GP_DIFF_PIN];
  // Differential pins used single-ended have no dual-edge registers
  wire dual_in = ctrl[`GP_DUAL_IN] & ~diff_pin;
  wire dual_out = ctrl[`GP_DUAL_OUT] & ~diff_pin;
  wire resync = ctrl[`GP_RESYNC];
  wire bypass = ctrl[`GP_BYPASS];
  wire pull_down_sel = ctrl[`GP_PULL_DOWN];

  wire mode_in = mode_is(mode, `GP_MODE_INPUT);
  wire mode_out = mode_is(mode, `GP_MODE_OUTPUT);
  wire mode_bidir = mode_is(mode, `GP_MODE_BIDIR);
  wire mode_clk = mode_is(mode, `GP_MODE_CLKOUT);
  wire rx_on = (mode_in & ~bypass) | mode_bidir;
  wire tx_on = mode_out | mode_bidir;

  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= `GP_CTRL_RESET;
    end else if (bus_done & we_i & hit_ctrl) begin
      if (sel_i[0]) begin
        ctrl[7:0] <= dat_i[7:0];
      end
      if (sel_i[1]) begin
        ctrl[`GP_CTRL_BITS-1:8] <= dat_i[`GP_CTRL_BITS-1:8];
      end
    end
  end

  // One wait state; ack falls the cycle after it is given
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= bus_req;
    end
  end

  reg [31:0] next_dat;
  always @* begin
    next_dat = 32'h00000000;
    if (hit_ctrl) begin
      next_dat[`GP_CTRL_BITS-1:0] = ctrl;
    end else if (hit_status) begin
      next_dat[`GP_ST_PAD] = pad_s2;
      next_dat[`GP_ST_RISE] = rise_sample_bit_o;
      next_dat[`GP_ST_FALL] = fall_sample_bit_o;
      next_dat[`GP_ST_DRIVE] = pad_oe_o;
      next_dat[`GP_ST_CONFIG] = config_active_i;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h00000000;
    end else if (bus_req & ~we_i) begin
      dat_o <= next_dat;
    end
  end

  // ****************************************************************
  // Synchronisers and clock edge detection
  // ****************************************************************
  reg cap_s1, cap_s2, cap_s3;
  reg lau_s1, lau_s2, lau_s3;
  reg tree_s1, tree_s2;

  always @(posedge clk_i) begin
    if (rst_i) begin
      pad_s1 <= 1'b0;
      pad_s2 <= 1'b0;
      // Preload from the pin so a clock idling high shows no false edge after reset
      cap_s1 <= capture_clock_i;
      cap_s2 <= cap_s1;
      cap_s3 <= cap_s2;
      lau_s1 <= launch_clock_i;
      lau_s2 <= lau_s1;
      lau_s3 <= lau_s2;
      tree_s1 <= 1'b0;
      tree_s2 <= 1'b0;
    end else begin
      pad_s1 <= pad_i;
      pad_s2 <= pad_s1;
      cap_s1 <= capture_clock_i;
      cap_s2 <= cap_s1;
      cap_s3 <= cap_s2;
      lau_s1 <= launch_clock_i;
      lau_s2 <= lau_s1;
      lau_s3 <= lau_s2;
      tree_s1 <= clock_tree_i;
      tree_s2 <= tree_s1;
    end
  end

  wire cap_rise = cap_s2 & ~cap_s3;
  wire cap_fall = ~cap_s2 & cap_s3;
  wire lau_rise = lau_s2 & ~lau_s3;
  wire lau_fall = ~lau_s2 & lau_s3;
  wire cap_edge = edge_hit(in_neg, cap_rise, cap_fall);
  wire lau_edge = edge_hit(out_neg, lau_rise, lau_fall);

  // ****************************************************************
  // Receive path
  // ****************************************************************
  // Leaving a receive mode clears the samples so the core never sees stale data
  reg fall_hold;

  always @(posedge clk_i) begin
    if (rst_i) begin
      rise_sample_bit_o <= 1'b0;
      fall_sample_bit_o <= 1'b0;
      fall_hold <= 1'b0;
    end else if (!rx_on) begin
      rise_sample_bit_o <= 1'b0;
      fall_sample_bit_o <= 1'b0;
      fall_hold <= 1'b0;
    end else if (dual_in) begin
      if (cap_fall) begin
        fall_hold <= pad_s2;
      end
      if (cap_rise) begin
        rise_sample_bit_o <= pad_s2;
        if (resync) begin
          fall_sample_bit_o <= fall_hold;
        end
      end
      if (cap_fall && !resync) begin
        fall_sample_bit_o <= pad_s2;
      end
    end else if (in_reg) begin
      if (cap_edge) begin
        rise_sample_bit_o <= pad_s2;
      end
    end else begin
      rise_sample_bit_o <= pad_s2;
    end
  end

  // Only the synchroniser and one output flop lie on this path; it never reaches the core
  always @(posedge clk_i) begin
    if (rst_i) begin
      bypass_input_o <= 1'b0;
    end else begin
      bypass_input_o <= mode_in & bypass & pad_s2;
    end
  end

  // ****************************************************************
  // Transmit and drive-enable path
  // ****************************************************************
  reg out_q, rise_q, fall_q, oe_q;

  always @(posedge clk_i) begin
    if (rst_i) begin
      out_q <= 1'b0;
      oe_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      if (lau_edge) begin
        out_q <= rise_drive_bit_i;
        oe_q <= drive_enable_i;
      end
      if (lau_rise) begin
        rise_q <= rise_drive_bit_i;
      end
      if (lau_fall) begin
        fall_q <= fall_drive_bit_i;
      end
    end
  end

  reg next_data;
  reg next_oe;
  always @* begin
    next_data = 1'b0;
    next_oe = 1'b0;
    if (mode_clk) begin
      next_data = tree_s2;
      next_oe = 1'b1;
    end else if (tx_on) begin
      if (dual_out) begin
        // Select on the delayed phase so the word captured on this edge is the one shown
        next_data = apply_inv(lau_s3 ? rise_q : fall_q, out_inv);
      end else if (out_reg) begin
        next_data = apply_inv(out_q, out_inv);
      end else begin
        next_data = rise_drive_bit_i;
      end
      if (mode_out) begin
        next_oe = 1'b1;
      end else if (out_reg) begin
        next_oe = oe_q;
      end else begin
        next_oe = drive_enable_i;
      end
    end
    // Configuration overrides every mode: the pin never drives before user mode
    if (config_active_i) begin
      next_oe = 1'b0;
    end
  end

  // ****************************************************************
  // Pad buffer and weak pulls
  // ****************************************************************
  reg next_up;
  reg next_down;
  always @* begin
    next_up = 1'b0;
    next_down = 1'b0;
    if (config_active_i) begin
      next_up = ~diff_pin;
    end else if (!next_oe) begin
      // Pad released; no pull-down exists on differential pins
      next_up = ~pull_down_sel;
      next_down = pull_down_sel & ~diff_pin;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      pad_o <= 1'b0;
      pad_oe_o <= 1'b0;
      pull_up_o <= 1'b1;
      pull_down_o <= 1'b0;
    end else begin
      pad_o <= next_data;
      pad_oe_o <= next_oe;
      pull_up_o <= next_up;
      pull_down_o <= next_down;
    end
  end

endmodule // gpio_pad_io_logic

//--- test/gpio_pad_io_logic_properties.sv
// Concurrent checks on the pad logic ports, bound to every instance.
// Assumes ctrl changes only through Wishbone writes at offset 0.
module gpio_pad_checker (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [3:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  input wire ack_o,
  input wire config_active_i,
  input wire clock_tree_i,
  input wire rise_drive_bit_i,
  input wire rise_sample_bit_o,
  input wire bypass_input_o,
  input wire pad_i,
  input wire pad_o,
  input wire pad_oe_o,
  input wire pull_up_o,
  input wire pull_down_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [13:0] cfg;
  wire [2:0] mode = cfg[2:0];
  // Shadow of ctrl, so mode-dependent paths can be judged from the ports alone
  always_ff @(posedge clk_i) begin
    if (rst_i) cfg <= 14'h0000;
    else if (cyc_i && stb_i && we_i && ack_o && adr_i == 4'h0) begin
      if (sel_i[0]) cfg[7:0] <= dat_i[7:0];
      if (sel_i[1]) cfg[13:8] <= dat_i[13:8];
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Synchronisers need a settled source, so the source must hold for five edges
  sequence still(c, s);
    (c && $stable(s) && $stable(cfg))[*5];
  endsequence
  a_ack_one_cycle: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_ack_next_edge: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack missing");
  a_input_follows_pad: assert property (
    still(mode == 3'h1 && cfg[11:8] == 4'h0 && !cfg[3], pad_i) |-> rise_sample_bit_o == pad_i)
    else $error("input path wrong");
  a_bypass_follows_pad: assert property (
    still(mode == 3'h1 && cfg[11], pad_i) |-> bypass_input_o == pad_i)
    else $error("bypass path wrong");
  a_output_plain_lag: assert property (
    (mode == 3'h2 && !cfg[5] && !cfg[9] && $stable(cfg))[*2]
    |-> pad_o == $past(rise_drive_bit_i))
    else $error("plain output wrong");
  a_clock_out_path: assert property (
    still(mode == 3'h4 && !config_active_i, clock_tree_i) |-> pad_o == clock_tree_i && pad_oe_o)
    else $error("clock out wrong");
  a_config_no_drive: assert property (config_active_i |=> !pad_oe_o)
    else $error("drives during configuration");
  a_config_pull_up: assert property (
    config_active_i && !cfg[13] |=> pull_up_o && !pull_down_o)
    else $error("no pull-up during configuration");
  a_config_diff_float: assert property (
    config_active_i && cfg[13] |=> !pull_up_o && !pull_down_o)
    else $error("pull on differential pin during configuration");
  a_unused_pulls: assert property (
    (mode == 3'h0 && !config_active_i && !cfg[13] && $stable(cfg))[*2]
    |-> pull_up_o == !cfg[12] && pull_down_o == cfg[12])
    else $error("unused pull wrong");
endmodule // gpio_pad_checker

bind gpio_pad_io_logic gpio_pad_checker gpio_pad_checker_i (.clk_i, .rst_i, .cyc_i, .stb_i,
  .we_i, .adr_i, .sel_i, .dat_i, .ack_o, .config_active_i, .clock_tree_i, .rise_drive_bit_i,
  .rise_sample_bit_o, .bypass_input_o, .pad_i, .pad_o, .pad_oe_o, .pull_up_o, .pull_down_o);

//--- test/pad_board.sv
// Board side of the pad: an optional driver, else the weak pulls.
// Assumes the pad enable is high while the design drives the pin.
module pad_board (
  input wire clk_i,
  input wire drive_i,
  input wire level_i,
  input wire pad_o,
  input wire pad_oe_o,
  input wire pull_up_o,
  input wire pull_down_o,
  output logic pad_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last = 1'b0;
  always @(posedge clk_i) last <= pad_i;
  // A line with nothing on it toggles, so a floating pad never reads as settled
  always_comb begin
    if (pad_oe_o) pad_i = pad_o;
    else if (drive_i) pad_i = level_i;
    else if (pull_up_o) pad_i = 1'b1;
    else if (pull_down_o) pad_i = 1'b0;
    else pad_i = !last;
  end
endmodule // pad_board

//--- test/gpio_pad_io_logic_tb.sv
// Self-checking bench for the pad logic, with a board model at the pad.
// Assumes 20 MHz clk_i; core clocks are slow levels stepped by the bench.
module gpio_pad_io_logic_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, drive = 0, level = 0;
  logic [3:0] adr_i = 4'h0, sel_i = 4'hf;
  logic [31:0] dat_i = 32'h0, dat_o, rdata;
  logic ack_o, config_active_i = 0, capture_clock_i = 0, launch_clock_i = 0, clock_tree_i = 0;
  logic rise_drive_bit_i = 0, fall_drive_bit_i = 0, drive_enable_i = 0;
  logic rise_sample_bit_o, fall_sample_bit_o, bypass_input_o, pad_i, pad_o, pad_oe_o;
  logic pull_up_o, pull_down_o;
  int n_fail = 0, total_checks = 0;

  gpio_pad_io_logic gpio_pad_io_logic_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
    .dat_i, .dat_o, .ack_o, .config_active_i, .capture_clock_i, .launch_clock_i, .clock_tree_i,
    .rise_drive_bit_i, .fall_drive_bit_i, .drive_enable_i, .rise_sample_bit_o,
    .fall_sample_bit_o, .bypass_input_o, .pad_i, .pad_o, .pad_oe_o, .pull_up_o, .pull_down_o);
  pad_board pad_board_i (.clk_i, .drive_i(drive), .level_i(level), .pad_o, .pad_oe_o,
    .pull_up_o, .pull_down_o, .pad_i);

  initial forever #25 clk_i = ~clk_i;

  task tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    int k;
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    sel_i <= s;
    adr_i <= a;
    dat_i <= d;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 20);
    if (ack_o !== 1'b1) begin
      n_fail++;
      stop_test;
    end
    rdata = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
    tick(1);
  endtask
  task set(input logic [13:0] v);
    wb(1'b1, 4'h0, {18'h0, v});
  endtask
  // Core clocks move only after the pad level has had time to settle
  task cap(input logic v);
    tick(8);
    capture_clock_i <= v;
    tick(8);
  endtask
  task lau(input logic v);
    tick(8);
    launch_clock_i <= v;
    tick(8);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_config;
    wb(1'b0, 4'h0, 32'h0);
    chk(rdata, 32'h0);
    config_active_i <= 1;
    tick(2);
    chk({pull_up_o, pull_down_o, pad_oe_o}, 32'h4);
    wb(1'b0, 4'h4, 32'h0);
    chk(rdata[4], 32'h1);
    set(14'h2000);
    tick(2);
    chk({pull_up_o, pull_down_o}, 32'h0);
    config_active_i <= 0;
    set(14'h1000);
    tick(2);
    chk({pull_up_o, pull_down_o, pad_oe_o}, 32'h2);
    wb(1'b1, 4'h8, 32'h3);
    wb(1'b0, 4'h8, 32'h0);
    chk(rdata, 32'h0);
    wb(1'b0, 4'h0, 32'h0);
    chk(rdata, 32'h1000);
    wb(1'b1, 4'h0, 32'h3fff, 4'h2);
    wb(1'b0, 4'h0, 32'h0);
    chk(rdata, 32'h3f00);
  endtask
  task t_input;
    set(14'h0001);
    drive <= 1;
    level <= 1;
    tick(5);
    chk({pad_oe_o, rise_sample_bit_o}, 32'h1);
    set(14'h0801);
    tick(5);
    chk(bypass_input_o, 32'h1);
    level <= 0;
    tick(5);
    chk(bypass_input_o, 32'h0);
  endtask
  task t_capture;
    set(14'h0009);
    cap(1);
    level <= 1;
    cap(0);
    chk(rise_sample_bit_o, 32'h0);
    cap(1);
    chk(rise_sample_bit_o, 32'h1);
    set(14'h0019);
    level <= 0;
    cap(0);
    chk(rise_sample_bit_o, 32'h0);
  endtask
  task t_dual_in;
    set(14'h0109);
    level <= 1;
    cap(1);
    level <= 0;
    cap(0);
    chk({rise_sample_bit_o, fall_sample_bit_o}, 32'h2);
    set(14'h0509);
    level <= 1;
    cap(1);
    chk({rise_sample_bit_o, fall_sample_bit_o}, 32'h2);
    cap(0);
    chk(fall_sample_bit_o, 32'h0);
    cap(1);
    chk({rise_sample_bit_o, fall_sample_bit_o}, 32'h3);
  endtask
  task t_output;
    drive <= 0;
    set(14'h0002);
    rise_drive_bit_i <= 1;
    tick(3);
    chk({pad_oe_o, pad_o}, 32'h3);
    set(14'h00a2);
    rise_drive_bit_i <= 0;
    lau(1);
    chk(pad_o, 32'h1);
    rise_drive_bit_i <= 1;
    lau(0);
    chk(pad_o, 32'h1);
    lau(1);
    chk(pad_o, 32'h0);
    lau(0);
    set(14'h0222);
    fall_drive_bit_i <= 0;
    lau(1);
    chk(pad_o, 32'h1);
    lau(0);
    chk(pad_o, 32'h0);
  endtask
  task t_bidir;
    set(14'h0003);
    rise_drive_bit_i <= 0;
    tick(6);
    chk({pad_oe_o, pull_up_o, rise_sample_bit_o}, 32'h3);
    drive_enable_i <= 1;
    tick(6);
    chk({pad_oe_o, pad_o, rise_sample_bit_o}, 32'h4);
    set(14'h0023);
    lau(1);
    drive_enable_i <= 0;
    lau(0);
    chk(pad_oe_o, 32'h1);
    lau(1);
    chk({pad_oe_o, rise_sample_bit_o}, 32'h1);
  endtask
  task t_clock_out;
    set(14'h0004);
    clock_tree_i <= 1;
    tick(8);
    chk({pad_oe_o, pad_o}, 32'h3);
    clock_tree_i <= 0;
    tick(8);
    chk({pad_oe_o, pad_o}, 32'h2);
  endtask

  initial begin
    tick(6);
    rst_i <= 0;
    tick(1);
    t_config;
    t_input;
    t_capture;
    t_dual_in;
    t_output;
    t_bidir;
    t_clock_out;
    stop_test;
  end
endmodule // gpio_pad_io_logic_tb
